// ===== sic_cfg.svh
// Offsets, field positions, reset values and timing counts
`ifndef SIC_CFG_SVH
`define SIC_CFG_SVH

// ****************************************
// Software register map (word addresses)
// ****************************************
`define SIC_ADR_CTRL 6'h00
`define SIC_ADR_SHADOW0 6'h01
`define SIC_ADR_STATUS 6'h09
`define SIC_CTRL_COMMIT_BIT 0
`define SIC_CTRL_THERMAL_BIT 1
`define SIC_SHADOW_RESET 24'h000000

// ****************************************
// Shadow word indices
// ****************************************
`define SIC_IDX_DEVCFG 3'h0
`define SIC_IDX_CHAN_EN 3'h1
`define SIC_IDX_SENSE 3'h2
`define SIC_IDX_SOURCE 3'h3
`define SIC_IDX_WC_A 3'h4
`define SIC_IDX_WC_B 3'h5
`define SIC_IDX_CCP_B 3'h6
`define SIC_IDX_MATRIX 3'h7
`define SIC_IDX_LAST 3'h7

// ****************************************
// Device register addresses on the link
// ****************************************
`define SIC_DEV_DEVCFG 6'h1A
`define SIC_DEV_CHAN_EN 6'h1B
`define SIC_DEV_SENSE 6'h32
`define SIC_DEV_SOURCE 6'h1C
`define SIC_DEV_WC_A 6'h2B
`define SIC_DEV_WC_B 6'h2C
`define SIC_DEV_CCP_B 6'h2E
`define SIC_DEV_MATRIX 6'h30

// ****************************************
// Device field positions and codes
// ****************************************
`define SIC_POLL_EN_BIT 0
`define SIC_SUPPLY_MEAS_BIT 16
`define SIC_DIAG_MSB 21
`define SIC_DIAG_LSB 18
`define SIC_MTX_MSB 4
`define SIC_MTX_LSB 3
`define SIC_MTX_5X5 2'h2
`define SIC_MTX_6X6 2'h3
`define SIC_AS_MSB 22
`define SIC_AS_LSB 21
`define SIC_AS_OFF 2'h3
`define SIC_WC_HIGH_MIN 3'h4
`define SIC_WC_1MA 3'h1
`define SIC_WC_2MA 3'h2
`define SIC_WC_SINK_MIN 3'h2
`define SIC_WC_SINK_2MA 3'h3
`define SIC_DIAG_SENSE 4'hF
`define SIC_DIAG_SOURCE 4'hC
`define SIC_ROW_LSB 4
`define SIC_COL_LSB 10

// ****************************************
// Serial link timing
// ****************************************
`define SIC_SCLK_HALF 8'h04
`define SIC_FRAME_LAST 6'h1F

`endif

// ===== sic_pkg.sv
// Types shared by the configuration host and its serialiser
package sic_pkg;

	typedef logic [31:0] word_type;
	typedef logic [23:0] field_type;
	typedef field_type [7:0] shadow_type;

	typedef struct packed {
		logic diag_src;
		logic diag_mode;
		logic diag_en;
		logic thermal;
		logic source;
		logic sense;
		logic enable;
		logic poll;
	} viol_type;

	typedef enum logic [2:0] {
		HST_IDLE = 3'b001,
		HST_LOAD = 3'b010,
		HST_WAIT = 3'b100
	} host_state_type;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b01,
		SER_SHIFT = 2'b10
	} ser_state_type;

endpackage : sic_pkg

// ===== sic_ser_if.sv
// Frame handoff between the host and the serialiser
`timescale 1ns/1ps
`default_nettype none
interface sic_ser_if;
	logic start;
	logic [31:0] frame;
	logic busy;
	modport master (output start, output frame, input busy);
	modport slave (input start, input frame, output busy);
endinterface : sic_ser_if
`default_nettype wire

// ===== sic_ser.sv
// Serialiser shifting one 32-bit frame out to the device
`timescale 1ns/1ps
`default_nettype none
`include "sic_cfg.svh"
module sic_ser (
	input wire logic clk,
	input wire logic reset_n,
	sic_ser_if.slave link,
	output logic sclk,
	output logic sel_n,
	output logic dout
);
	import sic_pkg::*;

	typedef struct packed {
		ser_state_type state;
		logic [31:0] shift;
		logic [5:0] cnt;
		logic [7:0] div;
		logic sclk;
		logic sel_n;
		logic dout;
		logic busy;
	} ser_reg_type;

	ser_reg_type s_q;
	ser_reg_type s_d;

	always_comb begin
		s_d = s_q;
		unique case (s_q.state)
			SER_IDLE: begin
				if (link.start) begin
					s_d.state = SER_SHIFT;
					s_d.shift = link.frame;
					s_d.dout = link.frame[31];
					s_d.sel_n = 1'b0;
					s_d.busy = 1'b1;
					s_d.cnt = 6'h00;
					s_d.div = 8'h00;
				end
			end
			SER_SHIFT: begin
				s_d.div = s_q.div + 8'h01;
				if (s_q.div == `SIC_SCLK_HALF - 8'h01) begin
					s_d.div = 8'h00;
					s_d.sclk = ~s_q.sclk;
					// Data moves on the falling edge only
					if (s_q.sclk) begin
						if (s_q.cnt == `SIC_FRAME_LAST) begin
							s_d.state = SER_IDLE;
							s_d.sel_n = 1'b1;
							s_d.busy = 1'b0;
						end else begin
							s_d.cnt = s_q.cnt + 6'h01;
							s_d.shift = {s_q.shift[30:0], 1'b0};
							s_d.dout = s_q.shift[30];
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '{state: SER_IDLE, shift: 32'h00000000, cnt: 6'h00,
				div: 8'h00, sclk: 1'b0, sel_n: 1'b1, dout: 1'b0,
				busy: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign link.busy = s_q.busy;
	assign sclk = s_q.sclk;
	assign sel_n = s_q.sel_n;
	assign dout = s_q.dout;
endmodule : sic_ser
`default_nettype wire

// ===== sic_host.sv
// Configuration host: shadows, legality checks and device download
// Functional notes
// [R1] 5x5 matrix needs size code 10 and polling enabled.
// [R2] 5x5 matrix needs channels 4-8 and 10-14 enabled.
// [R3] 5x5 matrix needs those channels in comparator sensing.
// [R4] 5x5 matrix: channels 4-8 sink, 10-14 source type.
// [R5] Thermal warning expected: source 1 or 2 mA, sink above it.
// [R6] 6x6 matrix needs size code 11 and polling enabled.
// [R7] 6x6 matrix needs channels 4-9 and 10-15 enabled.
// [R8] 6x6 matrix needs those channels in comparator sensing.
// [R9] 6x6 matrix: channels 4-9 sink, 10-15 source type.
// [R10] Clean polling active for a channel whose enable bit is one.
// [R11] Clean polling needs an enabled input or supply measurement.
// [R12] Auto-scaling selected when its field is not 11, continuous only.
// [R13] Auto-scaling applies only to wetting codes 100 to 111.
// [R14] Diagnostic selected needs one of channels 0-3 enabled.
// [R15] Diagnostic needs channels 0-3 in converter sensing.
// [R16] Diagnostic needs channels 0 and 1 as source type.
// [R17] Diagnostic needs channels 2 and 3 as sink type.
// [R18] Sensing bit zero means comparator, one means converter.
// [R19] Unmet clean polling precondition only makes the feature idle.
// [R20] Unmet auto-scaling preconditions only make the feature idle.
// [R21] Conflicting matrix or diagnostic programming raises a status flag.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sic_cfg.svh"
module sic_host (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire sic_pkg::word_type DAT_I,
	output var sic_pkg::word_type DAT_O,
	output logic ACK_O,
	output logic SER_CLK,
	output logic SER_SEL_N,
	output logic SER_DOUT
);
	import sic_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		host_state_type state;
		shadow_type shadow;
		logic thermal;
		logic [2:0] idx;
		logic refused;
		logic sent;
		viol_type viol_last;
		logic start;
		word_type frame;
		logic ack;
		word_type dat;
	} host_reg_type;

	host_reg_type h_q;
	host_reg_type h_d;
	sic_ser_if ser ();

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic pair_bad(logic [2:0] src, logic [2:0] snk);
		// [R5] thermal current pairing
		pair_bad = !((src == `SIC_WC_1MA && snk >= `SIC_WC_SINK_MIN) ||
			(src == `SIC_WC_2MA && snk == `SIC_WC_SINK_2MA));
	endfunction : pair_bad

	function automatic logic any_high(field_type f, int cnt);
		logic hit;
		hit = 1'b0;
		// [R13] only 10 or 15 mA codes
		for (int i = 0; i < cnt; i++) begin
			if (f[3*i+2 -: 3] >= `SIC_WC_HIGH_MIN) begin
				hit = 1'b1;
			end
		end
		any_high = hit;
	endfunction : any_high

	function automatic viol_type check_cfg(shadow_type c, logic therm);
		viol_type v;
		logic [1:0] size;
		logic mtx;
		logic diag;
		field_type run;
		field_type lo;
		field_type hi;
		field_type a;
		field_type b;
		size = c[`SIC_IDX_MATRIX][`SIC_MTX_MSB:`SIC_MTX_LSB];
		a = c[`SIC_IDX_WC_A];
		b = c[`SIC_IDX_WC_B];
		// [R1] 5x5 size code
		// [R6] 6x6 size code
		mtx = (size == `SIC_MTX_5X5) || (size == `SIC_MTX_6X6);
		run = (size == `SIC_MTX_6X6) ? 24'h00003F : 24'h00001F;
		lo = run << `SIC_ROW_LSB;
		hi = run << `SIC_COL_LSB;
		v = '0;
		// [R1] polling with matrix
		// [R6] polling with matrix
		v.poll = mtx && !c[`SIC_IDX_DEVCFG][`SIC_POLL_EN_BIT];
		// [R2] 5x5 channel enables
		// [R7] 6x6 channel enables
		v.enable = mtx && ((c[`SIC_IDX_CHAN_EN] & (lo | hi)) != (lo | hi));
		// [R3] 5x5 comparator sensing
		// [R8] 6x6 comparator sensing
		// [R18] zero is comparator
		v.sense = mtx && ((c[`SIC_IDX_SENSE] & (lo | hi)) != 24'h000000);
		// [R4] 5x5 sink and source
		// [R9] 6x6 sink and source
		v.source = mtx && ((c[`SIC_IDX_SOURCE] & (lo | hi)) != lo);
		// [R5] thermal pair limits
		v.thermal = mtx && therm && (pair_bad(a[8:6], a[20:18]) ||
			pair_bad(a[11:9], a[23:21]) || pair_bad(b[2:0], a[14:12]) ||
			pair_bad(b[5:3], a[17:15]));
		diag = c[`SIC_IDX_DEVCFG][`SIC_DIAG_MSB:`SIC_DIAG_LSB] != 4'h0;
		// [R14] diagnostic channel enable
		v.diag_en = diag && (c[`SIC_IDX_CHAN_EN][3:0] == 4'h0);
		// [R15] diagnostic converter sensing
		// [R18] one is converter
		v.diag_mode = diag && (c[`SIC_IDX_SENSE][3:0] != `SIC_DIAG_SENSE);
		// [R16] channels 0-1 source
		// [R17] channels 2-3 sink
		v.diag_src = diag && (c[`SIC_IDX_SOURCE][3:0] != `SIC_DIAG_SOURCE);
		check_cfg = v;
	endfunction : check_cfg

	function automatic logic [5:0] dev_adr(logic [2:0] idx);
		logic [5:0] r;
		r = `SIC_DEV_DEVCFG;
		unique case (idx)
			`SIC_IDX_DEVCFG: r = `SIC_DEV_DEVCFG;
			`SIC_IDX_CHAN_EN: r = `SIC_DEV_CHAN_EN;
			`SIC_IDX_SENSE: r = `SIC_DEV_SENSE;
			`SIC_IDX_SOURCE: r = `SIC_DEV_SOURCE;
			`SIC_IDX_WC_A: r = `SIC_DEV_WC_A;
			`SIC_IDX_WC_B: r = `SIC_DEV_WC_B;
			`SIC_IDX_CCP_B: r = `SIC_DEV_CCP_B;
			`SIC_IDX_MATRIX: r = `SIC_DEV_MATRIX;
		endcase
		dev_adr = r;
	endfunction : dev_adr

	function automatic field_type merge(field_type old, word_type wd,
		logic [3:0] sel);
		field_type r;
		r = old;
		for (int i = 0; i < 3; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// ****************************************
	// Next state
	// ****************************************
	viol_type viol;
	logic ccp_on;
	logic ccp_idle;
	logic as_sel;
	logic as_eff;
	logic [5:0] word_adr;
	logic [5:0] sh_off;
	logic [30:0] body;

	always_comb begin
		h_d = h_q;
		h_d.start = 1'b0;
		word_adr = ADR_I[7:2];
		sh_off = word_adr - `SIC_ADR_SHADOW0;
		body = 31'h00000000;
		viol = check_cfg(h_q.shadow, h_q.thermal);
		// [R10] any channel bit set
		ccp_on = h_q.shadow[`SIC_IDX_CCP_B] != 24'h000000;
		// [R11] input or supply needed
		// [R19] soft, no refusal
		ccp_idle = ccp_on && (h_q.shadow[`SIC_IDX_CHAN_EN] == 24'h000000) &&
			!h_q.shadow[`SIC_IDX_DEVCFG][`SIC_SUPPLY_MEAS_BIT];
		// [R12] selected unless 11
		as_sel = h_q.shadow[`SIC_IDX_WC_B][`SIC_AS_MSB:`SIC_AS_LSB] !=
			`SIC_AS_OFF;
		// [R12] continuous mode only
		// [R20] otherwise just idle
		as_eff = as_sel && !h_q.shadow[`SIC_IDX_DEVCFG][`SIC_POLL_EN_BIT] &&
			(any_high(h_q.shadow[`SIC_IDX_WC_A], 8) ||
			any_high(h_q.shadow[`SIC_IDX_WC_B], 7));

		// Ack one cycle after the strobe, dropped the next
		h_d.ack = CYC_I && STB_I && !h_q.ack;
		if (CYC_I && STB_I && !h_q.ack) begin
			h_d.dat = 32'h00000000;
			if (word_adr == `SIC_ADR_CTRL) begin
				h_d.dat[`SIC_CTRL_THERMAL_BIT] = h_q.thermal;
			end else if (word_adr == `SIC_ADR_STATUS) begin
				h_d.dat = {8'h00, h_q.viol_last, viol, 1'b0, as_eff,
					as_sel, ccp_idle, ccp_on, h_q.sent, h_q.refused,
					h_q.state != HST_IDLE};
			end else if (sh_off <= 6'(`SIC_IDX_LAST)) begin
				h_d.dat = {8'h00, h_q.shadow[sh_off[2:0]]};
			end
		end

		// Writes land on the acking edge; idle only, so a download
		// never mixes old and new words
		if (CYC_I && STB_I && WE_I && h_q.ack && h_q.state == HST_IDLE) begin
			if (word_adr == `SIC_ADR_CTRL && SEL_I[0]) begin
				h_d.thermal = DAT_I[`SIC_CTRL_THERMAL_BIT];
				if (DAT_I[`SIC_CTRL_COMMIT_BIT]) begin
					h_d.sent = 1'b0;
					// [R21] refuse conflicting set
					if (viol != '0) begin
						h_d.refused = 1'b1;
						h_d.viol_last = viol;
					end else begin
						h_d.refused = 1'b0;
						h_d.viol_last = '0;
						h_d.idx = `SIC_IDX_DEVCFG;
						h_d.state = HST_LOAD;
					end
				end
			end else if (sh_off <= 6'(`SIC_IDX_LAST)) begin
				h_d.shadow[sh_off[2:0]] =
					merge(h_q.shadow[sh_off[2:0]], DAT_I, SEL_I);
			end
		end

		// ****************************************
		// Download sequencer
		// ****************************************
		unique case (h_q.state)
			HST_IDLE: begin
			end
			HST_LOAD: begin
				body = {1'b1, dev_adr(h_q.idx), h_q.shadow[h_q.idx]};
				h_d.frame = {body, ~^body};
				h_d.start = 1'b1;
				h_d.state = HST_WAIT;
			end
			HST_WAIT: begin
				// Busy lags start by a cycle; skip that cycle
				if (!ser.busy && !h_q.start) begin
					if (h_q.idx == `SIC_IDX_LAST) begin
						h_d.state = HST_IDLE;
						h_d.sent = 1'b1;
					end else begin
						h_d.idx = h_q.idx + 3'h1;
						h_d.state = HST_LOAD;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			h_q <= '{state: HST_IDLE, shadow: {8{`SIC_SHADOW_RESET}},
				thermal: 1'b0, idx: 3'h0, refused: 1'b0, sent: 1'b0,
				viol_last: '0, start: 1'b0, frame: 32'h00000000,
				ack: 1'b0, dat: 32'h00000000};
		end else begin
			h_q <= h_d;
		end
	end

	assign ser.start = h_q.start;
	assign ser.frame = h_q.frame;
	assign ACK_O = h_q.ack;
	assign DAT_O = h_q.dat;

	sic_ser u_ser (
		.clk(CORE_CLK),
		.reset_n(RESET_N),
		.link(ser),
		.sclk(SER_CLK),
		.sel_n(SER_SEL_N),
		.dout(SER_DOUT)
	);
endmodule : sic_host
`default_nettype wire

// ===== sic_host_asserts.sv
// Port checker for the configuration host
`timescale 1ns/1ps
`default_nettype none
module sic_host_asserts (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire sic_pkg::word_type DAT_O,
	input wire logic ACK_O,
	input wire logic SER_CLK,
	input wire logic SER_SEL_N,
	input wire logic SER_DOUT
);
	import sic_pkg::*;
	logic [8:0] low_q;
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESET_N);
	sequence req_s;
		CYC_I && STB_I && !ACK_O;
	endsequence
	sequence clk_high_s;
		SER_CLK [*4] ##1 !SER_CLK;
	endsequence
	// Frame length counter, too long for a repetition
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N)
			low_q <= 9'h000;
		else
			low_q <= SER_SEL_N ? 9'h000 : low_q + 9'h001;
	end
	a_ack_next: assert property (req_s |=> ACK_O)
		else $error("ack missing after request");
	a_ack_pulse: assert property (ACK_O |=> !ACK_O)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (!(CYC_I && STB_I) |=> !ACK_O)
		else $error("ack without request");
	a_unmapped_zero: assert property (req_s and (!WE_I && ADR_I[7:2] > 6'h09)
		|=> DAT_O == 32'h00000000)
		else $error("unmapped read not zero");
	a_clk_idle: assert property (SER_SEL_N |-> !SER_CLK)
		else $error("serial clock runs outside frame");
	a_clk_half: assert property ($rose(SER_CLK) |-> clk_high_s)
		else $error("serial clock high phase wrong");
	a_dout_fall: assert property (!SER_SEL_N && !$past(SER_SEL_N)
		&& $changed(SER_DOUT) |-> $fell(SER_CLK))
		else $error("data moved off clock fall");
	a_frame_len: assert property ($rose(SER_SEL_N) |-> low_q == 9'h100)
		else $error("frame not 256 cycles");
	a_write_bit: assert property ($fell(SER_SEL_N) |-> SER_DOUT)
		else $error("frame does not start with write bit");
	a_sel_gap: assert property ($rose(SER_SEL_N) |=> SER_SEL_N)
		else $error("no gap between frames");
endmodule : sic_host_asserts
bind sic_host sic_host_asserts u_chk (.CORE_CLK(CORE_CLK),
	.RESET_N(RESET_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
	.ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .SER_CLK(SER_CLK),
	.SER_SEL_N(SER_SEL_N), .SER_DOUT(SER_DOUT));
`default_nettype wire

// ===== sic_dev_model.sv
// Device-side model collecting register frames
`timescale 1ns/1ps
`default_nettype none
module sic_dev_model (
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic din
);
	import sic_pkg::*;
	logic [31:0] sh;
	int nbits = 0;
	int bad = 0;
	int frames = 0;
	field_type regs [0:63];
	initial begin
		foreach (regs[i])
			regs[i] = 24'h000000;
	end
	always @(posedge sclk) begin
		if (!sel_n) begin
			sh = {sh[30:0], din};
			nbits++;
		end
	end
	// Fields kept raw; device decodes them later
	always @(posedge sel_n) begin
		if (nbits > 0) begin
			frames++;
			if (nbits != 32 || sh[31] !== 1'b1 || ^sh !== 1'b1)
				bad++;
			regs[sh[30:25]] = sh[24:1];
			nbits = 0;
		end
	end
endmodule : sic_dev_model
`default_nettype wire

// ===== sic_host_tb.sv
// Self-checking bench for the configuration host
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
$display("unexpected %s exp %h got %h", n, e, g); end end
module sic_host_tb;
	import sic_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	word_type dat_i = 32'h00000000;
	word_type dat_o;
	word_type q;
	logic ack;
	logic sclk;
	logic seln;
	logic dout;
	int fails = 0;
	int num_checks = 0;
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	sic_host DUT (.CORE_CLK(core_clk), .RESET_N(reset_n), .CYC_I(cyc),
		.STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat_i),
		.DAT_O(dat_o), .ACK_O(ack), .SER_CLK(sclk), .SER_SEL_N(seln),
		.SER_DOUT(dout));
	sic_dev_model dev (.sclk(sclk), .sel_n(seln), .din(dout));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	task automatic wb(input logic w, input logic [7:0] a, input word_type d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= d;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge core_clk);
		if (n >= 20) begin
			fails++;
			give_verdict;
		end
	endtask : wb
	task automatic setw(input logic [2:0] i, input logic [23:0] v);
		wb(1'b1, (8'(i) + 8'h01) << 2, {8'h00, v});
	endtask : setw
	task automatic stat(input word_type m, input word_type e);
		wb(1'b0, 8'h24, 32'h00000000);
		`CHK("status", e, q & m)
	endtask : stat
	// Break one field, expect its live cause, then mend it
	task automatic brk(input logic [2:0] i, input logic [23:0] b,
		input logic [23:0] g, input int k);
		setw(i, b);
		stat(32'h0000FF00, 32'h00000100 << k);
		setw(i, g);
	endtask : brk
	task automatic commit;
		int n;
		wb(1'b1, 8'h00, 32'h00000001);
		n = 0;
		do begin
			wb(1'b0, 8'h24, 32'h00000000);
			n++;
		end while (q[0] !== 1'b0 && n < 1000);
		if (n >= 1000) begin
			fails++;
			give_verdict;
		end
	endtask : commit
	initial begin
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		stat(32'h00FFFFFF, 32'h00000020);
		wb(1'b1, 8'h3C, 32'hFFFFFFFF);
		wb(1'b0, 8'h3C, 32'h00000000);
		`CHK("unmapped", 32'h00000000, q)
		wb(1'b1, 8'h1C, 32'hFFFFFFFF);
		wb(1'b0, 8'h1C, 32'h00000000);
		`CHK("shadow", 32'h00FFFFFF, q)
		stat(32'h00000018, 32'h00000018);
		setw(`SIC_IDX_DEVCFG, 24'h010000);
		stat(32'h00000018, 32'h00000008);
		setw(`SIC_IDX_CCP_B, 24'h000000);
		setw(`SIC_IDX_WC_B, 24'h000004);
		setw(`SIC_IDX_DEVCFG, 24'h000001);
		stat(32'h00000060, 32'h00000020);
		setw(`SIC_IDX_DEVCFG, 24'h000000);
		stat(32'h00000060, 32'h00000060);
		setw(`SIC_IDX_WC_B, 24'h600004);
		stat(32'h00000060, 32'h00000000);
		setw(`SIC_IDX_DEVCFG, 24'h000001);
		setw(`SIC_IDX_CHAN_EN, 24'h007DF0);
		setw(`SIC_IDX_SOURCE, 24'h0001F0);
		setw(`SIC_IDX_MATRIX, 24'h000010);
		stat(32'h0000FF00, 32'h00000000);
		brk(`SIC_IDX_DEVCFG, 24'h000000, 24'h000001, 0);
		brk(`SIC_IDX_CHAN_EN, 24'h007DE0, 24'h007DF0, 1);
		brk(`SIC_IDX_SENSE, 24'h000010, 24'h000000, 2);
		brk(`SIC_IDX_SOURCE, 24'h0005F0, 24'h0001F0, 3);
		setw(`SIC_IDX_SENSE, 24'h004000);
		commit;
		stat(32'h00FF0006, 32'h00040002);
		`CHK("frames", 0, dev.frames)
		setw(`SIC_IDX_SENSE, 24'h000000);
		commit;
		stat(32'h00000006, 32'h00000004);
		`CHK("frames", 8, dev.frames)
		`CHK("bad", 0, dev.bad)
		`CHK("mtx", 24'h000010, dev.regs[`SIC_DEV_MATRIX])
		`CHK("chan", 24'h007DF0, dev.regs[`SIC_DEV_CHAN_EN])
		setw(`SIC_IDX_CHAN_EN, 24'h00FFF0);
		setw(`SIC_IDX_SOURCE, 24'h0003F0);
		setw(`SIC_IDX_MATRIX, 24'h000018);
		stat(32'h0000FF00, 32'h00000000);
		brk(`SIC_IDX_DEVCFG, 24'h000000, 24'h000001, 0);
		brk(`SIC_IDX_CHAN_EN, 24'h007FF0, 24'h00FFF0, 1);
		brk(`SIC_IDX_SENSE, 24'h008000, 24'h000000, 2);
		brk(`SIC_IDX_SOURCE, 24'h000BF0, 24'h0003F0, 3);
		setw(`SIC_IDX_WC_A, 24'h492240);
		setw(`SIC_IDX_WC_B, 24'h000009);
		wb(1'b1, 8'h00, 32'h00000002);
		stat(32'h0000FF00, 32'h00000000);
		brk(`SIC_IDX_WC_B, 24'h00000B, 24'h000009, 4);
		brk(`SIC_IDX_WC_A, 24'h492280, 24'h492240, 4);
		wb(1'b1, 8'h00, 32'h00000000);
		setw(`SIC_IDX_DEVCFG, 24'h040001);
		setw(`SIC_IDX_CHAN_EN, 24'h00FFF1);
		setw(`SIC_IDX_SENSE, 24'h00000F);
		setw(`SIC_IDX_SOURCE, 24'h0003FC);
		stat(32'h0000FF00, 32'h00000000);
		brk(`SIC_IDX_CHAN_EN, 24'h00FFF0, 24'h00FFF1, 5);
		brk(`SIC_IDX_SENSE, 24'h00000E, 24'h00000F, 6);
		brk(`SIC_IDX_SOURCE, 24'h0003FD, 24'h0003FC, 7);
		brk(`SIC_IDX_SOURCE, 24'h0003F4, 24'h0003FC, 7);
		commit;
		`CHK("cfg", 24'h040001, dev.regs[`SIC_DEV_DEVCFG])
		`CHK("bad", 0, dev.bad)
		give_verdict;
	end
endmodule : sic_host_tb
`default_nettype wire
